/* File: rtl/dstf_framer.sv */
`timescale 1ns/1ns
`default_nettype none
module dstf_framer (
	input wire logic clk, // 100 MHz clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [6:0] node_addr, // own node address
	input wire logic rx_valid, // character received pulse
	input wire logic [7:0] rx_data, // received data bits
	input wire logic rx_par, // received parity bit
	output logic tx_valid, // character to send
	output logic [7:0] tx_data, // data bits to send
	output logic tx_par, // parity bit to send
	input wire logic tx_ready, // character layer takes it
	output logic tx_en, // line driver enable
	output logic req_valid, // parameter request pulse
	output dstf_pkg::dstf_req_t req, // parameter request
	output logic [7:0] rx_txt_data, // received text byte
	output logic rx_txt_valid, // text byte pulse
	input wire logic rsp_valid, // application answer
	input wire dstf_pkg::dstf_rsp_t rsp, // answer contents
	output logic rsp_ready, // answer taken
	input wire logic [7:0] txt_in_data, // text byte to send
	input wire logic txt_in_valid, // text byte offered
	output logic txt_in_ready, // text byte taken
	output logic [15:0] ctrl_word, // control word from master
	output logic [15:0] ref_word, // reference from master
	input wire logic [15:0] status_word, // status word to master
	input wire logic [15:0] out_freq, // present output frequency
	output logic frame_err // pulse on a telegram discarded at its check byte; a bad length byte drops it with no pulse
);
	localparam int IW = 8; // byte counter width

	// receive state
	dstf_pkg::dstf_rx_st_t rx_st_ff, nxt_rx_st; // receive sequencer
	logic [IW-1:0] rx_idx_ff, nxt_rx_idx; // data byte counter
	logic [7:0] rx_cnt_ff, nxt_rx_cnt; // data bytes expected
	logic [7:0] bcc_ff, nxt_bcc; // running check
	logic [7:0] adr_ff, nxt_adr; // address byte as received
	logic err_ff, nxt_err; // parity fault seen
	logic [7:0] buf_ff [dstf_pkg::PARAM_BUF], nxt_buf [dstf_pkg::PARAM_BUF]; // data block
	logic [15:0] ctrl_ff, nxt_ctrl; // control word
	logic [15:0] ref_ff, nxt_ref; // reference
	dstf_pkg::dstf_req_t req_ff, nxt_req; // request held
	logic req_v_ff, nxt_req_v; // request pulse
	logic [7:0] rtxt_ff, nxt_rtxt; // text byte out
	logic rtxt_v_ff, nxt_rtxt_v; // text pulse
	logic ferr_ff, nxt_ferr; // discard pulse
	logic hit; // address concerns us
	logic bcast; // broadcast address
	logic par_ok; // parity of current character
	logic accept; // good telegram ends now
	logic start_proc; // reply at once, process only
	logic start_param; // wait for application

	// transmit state
	dstf_pkg::dstf_tx_st_t tx_st_ff, nxt_tx_st; // transmit sequencer
	logic [7:0] tb_ff [dstf_pkg::PARAM_BUF], nxt_tb [dstf_pkg::PARAM_BUF]; // reply block
	logic [7:0] tcnt_ff, nxt_tcnt; // reply data bytes
	logic [IW-1:0] tk_ff, nxt_tk; // next byte to load
	logic [7:0] tbcc_ff, nxt_tbcc; // reply check
	logic [7:0] td_ff, nxt_td; // byte on offer
	logic tv_ff, nxt_tv; // byte on offer valid
	logic [7:0] tadr_ff, nxt_tadr; // echoed address
	logic [3:0] tcmd_ff, nxt_tcmd; // command being answered
	logic load; // slot free for a new byte
	logic [7:0] byte_k; // byte at position tk
	logic txt_pos; // position holds a text byte

	// picks response nibble from command and answer
	function automatic logic [3:0] rsp_code(input logic [3:0] cmd, input logic fault,
		input logic dword);
		logic [3:0] r;
		r = dstf_pkg::RSP_FAIL;
		case (cmd)
			dstf_pkg::CMD_NONE: r = dstf_pkg::RSP_NONE;
			dstf_pkg::CMD_READ: r = dword ? dstf_pkg::RSP_DWORD : dstf_pkg::RSP_WORD;
			dstf_pkg::CMD_WR_W, dstf_pkg::CMD_WR_W_NV: r = dstf_pkg::RSP_WORD;
			dstf_pkg::CMD_WR_D, dstf_pkg::CMD_WR_D_NV: r = dstf_pkg::RSP_DWORD;
			dstf_pkg::CMD_TEXT: r = dstf_pkg::RSP_TEXT;
			default: r = dstf_pkg::RSP_FAIL;
		endcase
		if (fault)
			r = dstf_pkg::RSP_FAIL;
		return r;
	endfunction : rsp_code

	dstf_addr_dec u_adr (
		.adr_byte(rx_st_ff == dstf_pkg::RX_ADR ? rx_data : adr_ff),
		.node_addr(node_addr),
		.hit(hit),
		.bcast(bcast)
	);

	// receive sequencer, next values
	always_comb
	begin
		nxt_rx_st = rx_st_ff;
		nxt_rx_idx = rx_idx_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_bcc = bcc_ff;
		nxt_adr = adr_ff;
		nxt_err = err_ff;
		nxt_buf = buf_ff;
		nxt_ctrl = ctrl_ff;
		nxt_ref = ref_ff;
		nxt_req = req_ff;
		nxt_req_v = 1'b0;
		nxt_rtxt = rtxt_ff;
		nxt_rtxt_v = 1'b0;
		nxt_ferr = 1'b0;
		accept = 1'b0;
		par_ok = (dstf_pkg::dstf_parity(rx_data) == rx_par);
		if (rx_valid)
		begin
			nxt_bcc = bcc_ff ^ rx_data;
			nxt_err = err_ff || !par_ok;
			case (rx_st_ff)
				dstf_pkg::RX_IDLE:
				begin
					// half duplex: nothing is taken while a reply is pending
					if (rx_data == dstf_pkg::STX_BYTE && tx_st_ff == dstf_pkg::TX_IDLE)
					begin
						nxt_bcc = dstf_pkg::BCC_RESET ^ rx_data;
						nxt_err = !par_ok;
						nxt_rx_st = dstf_pkg::RX_LEN;
					end
				end
				dstf_pkg::RX_LEN:
				begin
					nxt_rx_cnt = rx_data - dstf_pkg::LGE_OVERHEAD;
					// only process or parameter blocks, texts run longer
					if (rx_data == dstf_pkg::LGE_MIN || rx_data >= dstf_pkg::PARAM_BYTES
						+ dstf_pkg::LGE_OVERHEAD)
						nxt_rx_st = dstf_pkg::RX_ADR;
					else
						nxt_rx_st = dstf_pkg::RX_IDLE;
				end
				dstf_pkg::RX_ADR:
				begin
					nxt_adr = rx_data;
					nxt_rx_idx = '0;
					nxt_rx_st = dstf_pkg::RX_DATA;
				end
				dstf_pkg::RX_DATA:
				begin
					if (rx_idx_ff < IW'(dstf_pkg::PARAM_BUF))
						nxt_buf[rx_idx_ff[3:0]] = rx_data;
					else if (hit)
					begin
						nxt_rtxt = rx_data;
						nxt_rtxt_v = 1'b1;
					end
					nxt_rx_idx = rx_idx_ff + 1'b1;
					if (rx_idx_ff == rx_cnt_ff - 1'b1)
						nxt_rx_st = dstf_pkg::RX_CHK;
				end
				dstf_pkg::RX_CHK:
				begin
					nxt_rx_st = dstf_pkg::RX_IDLE;
					// discard on check, parity or address mismatch
					if (!nxt_err && bcc_ff == rx_data && hit)
						accept = 1'b1;
					else
						nxt_ferr = 1'b1;
				end
				default: nxt_rx_st = dstf_pkg::RX_IDLE;
			endcase
		end
		if (accept)
		begin
			if (rx_cnt_ff == dstf_pkg::PROC_BYTES)
			begin
				nxt_ctrl = {buf_ff[0], buf_ff[1]};
				nxt_ref = {buf_ff[2], buf_ff[3]};
			end
			else
			begin
				nxt_ctrl = {buf_ff[dstf_pkg::PCD_POS], buf_ff[dstf_pkg::PCD_POS+1]};
				nxt_ref = {buf_ff[dstf_pkg::PCD_POS+2], buf_ff[dstf_pkg::PCD_POS+3]};
				nxt_req.bcast = bcast;
				nxt_req.cmd = buf_ff[0][7:4];
				nxt_req.param_number_field = {buf_ff[0][3:0], buf_ff[1]};
				nxt_req.idx_hi = buf_ff[2];
				nxt_req.subidx = buf_ff[3];
				nxt_req.value = {buf_ff[4], buf_ff[5], buf_ff[6], buf_ff[7]};
				nxt_req.txt_len = rx_cnt_ff - dstf_pkg::PARAM_BYTES;
				nxt_req_v = 1'b1;
			end
		end
		start_proc = accept && !bcast && rx_cnt_ff == dstf_pkg::PROC_BYTES;
		start_param = accept && !bcast && rx_cnt_ff != dstf_pkg::PROC_BYTES;
	end

	// receive sequencer, registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rx_st_ff <= dstf_pkg::RX_IDLE;
			rx_idx_ff <= '0;
			rx_cnt_ff <= 8'h00;
			bcc_ff <= dstf_pkg::BCC_RESET;
			adr_ff <= 8'h00;
			err_ff <= 1'b0;
			buf_ff <= '{default: 8'h00};
			ctrl_ff <= 16'h0000;
			ref_ff <= 16'h0000;
			req_ff <= '0;
			req_v_ff <= 1'b0;
			rtxt_ff <= 8'h00;
			rtxt_v_ff <= 1'b0;
			ferr_ff <= 1'b0;
		end
		else
		begin
			rx_st_ff <= nxt_rx_st;
			rx_idx_ff <= nxt_rx_idx;
			rx_cnt_ff <= nxt_rx_cnt;
			bcc_ff <= nxt_bcc;
			adr_ff <= nxt_adr;
			err_ff <= nxt_err;
			buf_ff <= nxt_buf;
			ctrl_ff <= nxt_ctrl;
			ref_ff <= nxt_ref;
			req_ff <= nxt_req;
			req_v_ff <= nxt_req_v;
			rtxt_ff <= nxt_rtxt;
			rtxt_v_ff <= nxt_rtxt_v;
			ferr_ff <= nxt_ferr;
		end
	end

	// transmit sequencer, next values
	always_comb
	begin
		nxt_tx_st = tx_st_ff;
		nxt_tb = tb_ff;
		nxt_tcnt = tcnt_ff;
		nxt_tk = tk_ff;
		nxt_tbcc = tbcc_ff;
		nxt_td = td_ff;
		nxt_tv = tv_ff;
		nxt_tadr = tadr_ff;
		nxt_tcmd = tcmd_ff;
		load = (!tv_ff || tx_ready) && tx_st_ff == dstf_pkg::TX_SEND;
		txt_pos = tk_ff >= IW'(dstf_pkg::PARAM_BUF) + 8'h03 && tk_ff < tcnt_ff + 8'h03;
		byte_k = tbcc_ff;
		if (tk_ff == 8'h00)
			byte_k = dstf_pkg::STX_BYTE;
		else if (tk_ff == 8'h01)
			byte_k = tcnt_ff + dstf_pkg::LGE_OVERHEAD;
		else if (tk_ff == 8'h02)
			byte_k = tadr_ff;
		else if (txt_pos)
			byte_k = txt_in_data;
		else if (tk_ff < tcnt_ff + 8'h03)
			byte_k = tb_ff[4'(tk_ff - 8'h03)];
		txt_in_ready = load && txt_pos;
		rsp_ready = tx_st_ff == dstf_pkg::TX_WAIT;
		if (tv_ff && tx_ready)
			nxt_tv = 1'b0;
		case (tx_st_ff)
			dstf_pkg::TX_IDLE:
			begin
				nxt_tadr = adr_ff;
				nxt_tcmd = nxt_req.cmd;
				nxt_tk = '0;
				nxt_tbcc = dstf_pkg::BCC_RESET;
				if (start_proc)
				begin
					nxt_tb[0] = status_word[15:8];
					nxt_tb[1] = status_word[7:0];
					nxt_tb[2] = out_freq[15:8];
					nxt_tb[3] = out_freq[7:0];
					nxt_tcnt = dstf_pkg::PROC_BYTES;
					nxt_tx_st = dstf_pkg::TX_SEND;
				end
				else if (start_param)
					nxt_tx_st = dstf_pkg::TX_WAIT;
			end
			dstf_pkg::TX_WAIT:
			begin
				if (rsp_valid)
				begin
					nxt_tb[0] = {rsp_code(tcmd_ff, rsp.fault, rsp.dword), req_ff.param_number_field[11:8]};
					nxt_tb[1] = req_ff.param_number_field[7:0];
					nxt_tb[2] = req_ff.idx_hi;
					nxt_tb[3] = req_ff.subidx;
					// fault code sits in the low value word
					{nxt_tb[4], nxt_tb[5], nxt_tb[6], nxt_tb[7]} = rsp.fault ?
						{16'h0000, rsp.fault_code} : rsp.value;
					{nxt_tb[8], nxt_tb[9]} = status_word;
					{nxt_tb[10], nxt_tb[11]} = out_freq;
					nxt_tcnt = dstf_pkg::PARAM_BYTES + (tcmd_ff == dstf_pkg::CMD_TEXT
						? rsp.txt_len : 8'h00);
					nxt_tx_st = dstf_pkg::TX_SEND;
				end
			end
			dstf_pkg::TX_SEND:
			begin
				// a text byte not yet offered stalls the reply
				// nothing more is loaded once the check byte is on offer
				if (load && tk_ff <= tcnt_ff + 8'h03 && (!txt_pos || txt_in_valid))
				begin
					nxt_td = byte_k;
					nxt_tv = 1'b1;
					nxt_tk = tk_ff + 1'b1;
					nxt_tbcc = tbcc_ff ^ byte_k;
				end
				if (tk_ff == tcnt_ff + 8'h04 && (!tv_ff || tx_ready))
					nxt_tx_st = dstf_pkg::TX_IDLE;
			end
			default: nxt_tx_st = dstf_pkg::TX_IDLE;
		endcase
	end

	// transmit sequencer, registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_st_ff <= dstf_pkg::TX_IDLE;
			tb_ff <= '{default: 8'h00};
			tcnt_ff <= 8'h00;
			tk_ff <= '0;
			tbcc_ff <= dstf_pkg::BCC_RESET;
			td_ff <= 8'h00;
			tv_ff <= 1'b0;
			tadr_ff <= 8'h00;
			tcmd_ff <= dstf_pkg::CMD_NONE;
		end
		else
		begin
			tx_st_ff <= nxt_tx_st;
			tb_ff <= nxt_tb;
			tcnt_ff <= nxt_tcnt;
			tk_ff <= nxt_tk;
			tbcc_ff <= nxt_tbcc;
			td_ff <= nxt_td;
			tv_ff <= nxt_tv;
			tadr_ff <= nxt_tadr;
			tcmd_ff <= nxt_tcmd;
		end
	end

	// outputs
	assign tx_valid = tv_ff;
	assign tx_data = td_ff;
	assign tx_par = dstf_pkg::dstf_parity(td_ff);
	assign tx_en = tx_st_ff == dstf_pkg::TX_SEND;
	assign req_valid = req_v_ff;
	assign req = req_ff;
	assign rx_txt_data = rtxt_ff;
	assign rx_txt_valid = rtxt_v_ff;
	assign ctrl_word = ctrl_ff;
	assign ref_word = ref_ff;
	assign frame_err = ferr_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_stx_clears;
		rx_st_ff == dstf_pkg::RX_IDLE && rx_valid && rx_data == dstf_pkg::STX_BYTE
			&& tx_st_ff == dstf_pkg::TX_IDLE |=> bcc_ff == dstf_pkg::STX_BYTE;
	endproperty
	a_stx_clears: assert property (p_stx_clears) else $error("check not restarted");
	property p_no_bcast_reply;
		accept && bcast |=> tx_st_ff == dstf_pkg::TX_IDLE ##1 !tx_en;
	endproperty
	a_no_bcast_reply: assert property (p_no_bcast_reply) else $error("broadcast answered");
	property p_adr_echo;
		tv_ff && tk_ff == 8'h03 |-> td_ff == tadr_ff;
	endproperty
	a_adr_echo: assert property (p_adr_echo) else $error("address not echoed");
	property p_stx_first;
		tv_ff && tk_ff == 8'h01 |-> td_ff == dstf_pkg::STX_BYTE;
	endproperty
	a_stx_first: assert property (p_stx_first) else $error("reply lacks start byte");
	property p_len_byte;
		tv_ff && tk_ff == 8'h02 |-> td_ff == tcnt_ff + dstf_pkg::LGE_OVERHEAD;
	endproperty
	a_len_byte: assert property (p_len_byte) else $error("wrong length byte");
	property p_fault_nibble;
		rsp_valid && rsp_ready && rsp.fault |=> tb_ff[0][7:4] == dstf_pkg::RSP_FAIL;
	endproperty
	a_fault_nibble: assert property (p_fault_nibble) else $error("fault not flagged");
	property p_proc_reply;
		start_proc |=> tx_en && tcnt_ff == dstf_pkg::PROC_BYTES;
	endproperty
	a_proc_reply: assert property (p_proc_reply) else $error("process reply missing");
	property p_quiet;
		tx_st_ff == dstf_pkg::TX_IDLE && !start_proc |=> !tx_en;
	endproperty
	a_quiet: assert property (p_quiet) else $error("line driven unasked");
endmodule : dstf_framer
`default_nettype wire

/* File: include/dstf_pkg.sv */
// shared constants and types for the serial telegram framer
package dstf_pkg;
	// framing bytes
	localparam logic [7:0] STX_BYTE = 8'h02;
	localparam logic [7:0] LGE_OVERHEAD = 8'h02; // address plus check byte
	localparam logic [7:0] LGE_MIN = 8'h06; // shortest legal length byte
	localparam logic [7:0] PROC_BYTES = 8'h04;
	localparam logic [7:0] PARAM_BYTES = 8'h0c;
	localparam int PARAM_BUF = 12; // bytes held of a data block
	localparam int PCD_POS = 8; // process words in a parameter block
	localparam logic [7:0] BCC_RESET = 8'h00;
	// command nibble values, master to slave
	localparam logic [3:0] CMD_NONE = 4'h0;
	localparam logic [3:0] CMD_READ = 4'h1;
	localparam logic [3:0] CMD_WR_W = 4'h2;
	localparam logic [3:0] CMD_WR_D = 4'h3;
	localparam logic [3:0] CMD_WR_D_NV = 4'hd;
	localparam logic [3:0] CMD_WR_W_NV = 4'he;
	localparam logic [3:0] CMD_TEXT = 4'hf;
	// response nibble values, slave to master
	localparam logic [3:0] RSP_NONE = 4'h0;
	localparam logic [3:0] RSP_WORD = 4'h1;
	localparam logic [3:0] RSP_DWORD = 4'h2;
	localparam logic [3:0] RSP_FAIL = 4'h7;
	localparam logic [3:0] RSP_TEXT = 4'hf;
	// fault report codes for the low value word
	localparam logic [15:0] FLT_NO_PARAM = 16'h0000;
	localparam logic [15:0] FLT_NO_WRITE = 16'h0001;
	localparam logic [15:0] FLT_LIMIT = 16'h0002;
	localparam logic [15:0] FLT_NO_SUBIDX = 16'h0003;
	localparam logic [15:0] FLT_NOT_ARRAY = 16'h0004;
	localparam logic [15:0] FLT_TYPE = 16'h0005;
	localparam logic [15:0] FLT_MODE = 16'h0011;
	localparam logic [15:0] FLT_NO_BUS = 16'h0082;
	localparam logic [15:0] FLT_FACTORY = 16'h0083;
	// index high byte for text access, set by the master
	localparam logic [7:0] TXT_RD = 8'h04;
	localparam logic [7:0] TXT_WR = 8'h05;
	// parameter data type codes; no field of the request or the answer carries them
	localparam logic [7:0] DT_INT16 = 8'h03;
	localparam logic [7:0] DT_INT32 = 8'h04;
	localparam logic [7:0] DT_UINT8 = 8'h05;
	localparam logic [7:0] DT_UINT16 = 8'h06;
	localparam logic [7:0] DT_UINT32 = 8'h07;
	localparam logic [7:0] DT_TEXT = 8'h09;
	localparam logic [7:0] DT_BYTES = 8'h0a;
	localparam logic [7:0] DT_TIME = 8'h0d;
	localparam logic [7:0] DT_BITS = 8'h23;
	// receive and transmit sequencer states
	typedef enum logic [2:0] {RX_IDLE, RX_LEN, RX_ADR, RX_DATA, RX_CHK} dstf_rx_st_t;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} dstf_tx_st_t;
	// decoded parameter request handed to the application
	typedef struct packed {
		logic bcast; // no reply will follow
		logic [3:0] cmd; // command nibble
		logic [11:0] param_number_field; // parameter number
		logic [7:0] idx_hi; // text read or write selector
		logic [7:0] subidx; // low index byte
		logic [31:0] value; // whole-number value
		logic [7:0] txt_len; // text bytes beyond the fixed block
	} dstf_req_t;
	// application answer to a parameter request
	typedef struct packed {
		logic fault; // command cannot be performed
		logic dword; // value is a double word
		logic [15:0] fault_code; // fault report
		logic [31:0] value; // present value
		logic [7:0] txt_len; // text bytes to append
	} dstf_rsp_t;
	// even parity over a character
	function automatic logic dstf_parity(input logic [7:0] b);
		return ^b;
	endfunction : dstf_parity
endpackage : dstf_pkg

/* File: rtl/dstf_addr_dec.sv */
`timescale 1ns/1ns
`default_nettype none
// address byte decode for both formats
module dstf_addr_dec (
	input wire logic [7:0] adr_byte, // received address byte
	input wire logic [6:0] node_addr, // own node address
	output logic hit, // telegram concerns this node
	output logic bcast // telegram is a broadcast
);
	logic long_fmt; // long format selected by bit 7
	logic own; // individual match

	// format select and match
	always_comb
	begin
		long_fmt = adr_byte[7];
		if (long_fmt)
		begin
			bcast = (adr_byte[6:0] == 7'h00);
			own = (adr_byte[6:0] == node_addr);
		end
		else
		begin
			bcast = adr_byte[5];
			// bit 6 ignored, node above 31 cannot be reached here
			own = !adr_byte[5] && (node_addr[6:5] == 2'h0)
				&& (adr_byte[4:0] == node_addr[4:0]);
		end
		hit = bcast || (own && node_addr != 7'h00);
	end
endmodule : dstf_addr_dec
`default_nettype wire

/* File: sim/dstf_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
// bus master stand-in: sends request characters, takes reply characters
module dstf_master_model (
	input wire logic clk, // device clock
	output logic rx_valid, // character strobe to device
	output logic [7:0] rx_data, // character bits
	output logic rx_par, // parity bit
	input wire logic tx_valid, // reply character offered
	input wire logic [7:0] tx_data, // reply character bits
	input wire logic tx_par, // reply parity bit
	output logic tx_ready // reply character taken
);
	logic [7:0] got[$]; // reply characters collected
	int par_bad = 0; // reply characters with odd parity
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_par = 1'b0;
		tx_ready = 1'b0;
	end
	// one character per cycle, back to back; bad_par spoils one parity bit
	task automatic send(input logic [7:0] b[$], input int bad_par);
		for (int i = 0; i < b.size(); i++)
		begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = b[i];
			rx_par = (^b[i]) ^ (i == bad_par);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data = ~rx_data; // released line never shows the old byte
		rx_par = ~rx_par;
	endtask : send
	// intake stalls now and then, so slow and prompt takes both occur
	always @(negedge clk)
		tx_ready <= ($urandom % 4) != 0;
	// collect reply characters and watch their parity
	always @(posedge clk)
		if (tx_valid && tx_ready)
		begin
			got.push_back(tx_data);
			if (tx_par !== ^tx_data)
				par_bad++;
		end
endmodule : dstf_master_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
// self-checking bench: master model on the line, bench plays the application
module tb;
	logic clk = 1'b0; // device clock
	logic rst_n = 1'b0; // reset, active low
	logic [6:0] node_addr = 7'h05; // own node address
	logic rx_valid, rx_par, tx_valid, tx_par, tx_ready, tx_en, req_valid; // strobes
	logic rx_txt_valid, rsp_ready, txt_in_ready, frame_err, en_d; // other outputs
	logic [7:0] rx_data, tx_data, rx_txt_data, txt_in_data, txt_q; // character bytes
	logic rsp_valid = 1'b0; // answer offered whenever asked for
	logic txt_in_valid = 1'b1; // text source never runs dry
	logic [15:0] ctrl_word, ref_word; // process words out
	logic [15:0] last_cw = 16'h0000; // expected control word
	logic [15:0] last_rw = 16'h0000; // expected reference
	logic [15:0] status_word = 16'h0000; // status to master
	logic [15:0] out_freq = 16'h0000; // frequency to master
	dstf_pkg::dstf_req_t req, req_q; // request and its capture
	dstf_pkg::dstf_rsp_t rsp = '0; // answer contents
	int fe_cnt = 0, en_cnt = 0, rq_cnt = 0, txt_cnt = 0, txt_k = 0; // event counters
	int mismatches = 0, comparisons = 0; // verdict counters
	logic [7:0] adrs[8] = '{8'h05, 8'h45, 8'h85, 8'h25, 8'h65, 8'h80, 8'h06, 8'h86}; // corners
	logic [3:0] cmds[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf, 4'h5}; // 5 is undefined
	logic [15:0] flts[9] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h11, 16'h82, 16'h83};
	always #5 clk = ~clk; // 100 MHz
	dstf_framer dut (.clk(clk), .rst_n(rst_n), .node_addr(node_addr), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_par(rx_par), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_par(tx_par), .tx_ready(tx_ready), .tx_en(tx_en), .req_valid(req_valid), .req(req),
		.rx_txt_data(rx_txt_data), .rx_txt_valid(rx_txt_valid), .rsp_valid(rsp_valid),
		.rsp(rsp), .rsp_ready(rsp_ready), .txt_in_data(txt_in_data),
		.txt_in_valid(txt_in_valid), .txt_in_ready(txt_in_ready), .ctrl_word(ctrl_word),
		.ref_word(ref_word), .status_word(status_word), .out_freq(out_freq),
		.frame_err(frame_err));
	dstf_master_model mst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_par(rx_par),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_par(tx_par), .tx_ready(tx_ready));
	// the application answers as soon as the device waits
	always @(negedge clk)
		rsp_valid <= rsp_ready;
	// text bytes to append count up from a0 within each reply
	always_comb
		txt_in_data = 8'ha0 + 8'(txt_k);
	// event counters seen at the device outputs
	always @(posedge clk)
	begin
		en_d <= tx_en;
		if (tx_en && !en_d)
			en_cnt++;
		if (frame_err)
			fe_cnt++;
		if (rx_txt_valid)
		begin
			txt_cnt++;
			txt_q <= rx_txt_data;
		end
		if (req_valid)
		begin
			req_q <= req;
			rq_cnt++;
			txt_k <= 0;
		end
		else if (txt_in_valid && txt_in_ready)
			txt_k <= txt_k + 1;
	end
	// end of run: counts, then the verdict
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// telegram from the low n bytes of d, high byte first, check byte last
	function automatic void frame(input logic [7:0] adr, input logic [255:0] d, input int n,
		output logic [7:0] f[$]);
		logic [7:0] x;
		f = {8'h02, 8'(n + 2), adr};
		for (int i = n - 1; i >= 0; i--)
			f.push_back(d[8 * i +: 8]);
		x = 8'h00;
		foreach (f[i])
			x = x ^ f[i];
		f.push_back(x);
	endfunction : frame
	// 0 answered, 1 broadcast, 2 discarded
	function automatic int kind_of(input logic [6:0] nd, input logic [7:0] a);
		if (a[7])
			return (a[6:0] == 7'h00) ? 1 : ((a[6:0] == nd) ? 0 : 2);
		return a[5] ? 1 : (({2'b00, a[4:0]} == nd) ? 0 : 2);
	endfunction : kind_of
	function automatic logic [3:0] exp_nib(input logic [3:0] c, input logic flt, input logic dw);
		if (flt)
			return dstf_pkg::RSP_FAIL;
		case (c)
			dstf_pkg::CMD_NONE: return dstf_pkg::RSP_NONE;
			dstf_pkg::CMD_READ: return dw ? dstf_pkg::RSP_DWORD : dstf_pkg::RSP_WORD;
			dstf_pkg::CMD_WR_W, dstf_pkg::CMD_WR_W_NV: return dstf_pkg::RSP_WORD;
			dstf_pkg::CMD_WR_D, dstf_pkg::CMD_WR_D_NV: return dstf_pkg::RSP_DWORD;
			dstf_pkg::CMD_TEXT: return dstf_pkg::RSP_TEXT;
			default: return dstf_pkg::RSP_FAIL;
		endcase
	endfunction : exp_nib
	// reply against expectation; with skip set the check byte is left to the sum
	task automatic cmp(input logic [7:0] e[$], input bit skip);
		logic [7:0] x;
		x = 8'h00;
		foreach (mst.got[i])
			x = x ^ mst.got[i];
		check(mst.got.size(), e.size());
		check(x, 0);
		check(mst.par_bad, 0);
		foreach (e[i])
			if (!(skip && i == e.size() - 1))
				check(mst.got[i], e[i]);
	endtask : cmp
	// send one telegram, then wait for the reply or for quiet
	task automatic run(input logic [7:0] f[$], input int badp, input int kind);
		int fe0, en0, n;
		fe0 = fe_cnt;
		en0 = en_cnt;
		mst.got.delete();
		mst.send(f, badp);
		n = 0;
		while (n < ((kind == 0) ? 600 : 40) && !(kind == 0 && en_cnt != en0 && tx_en === 1'b0))
		begin
			@(negedge clk);
			n++;
		end
		check(fe_cnt - fe0, (kind == 2) ? 1 : 0);
		check(en_cnt - en0, (kind == 0) ? 1 : 0);
	endtask : run
	// process telegram; bad 1 spoils the check byte, bad 2 a parity bit
	task automatic proc(input logic [6:0] nd, input logic [7:0] adr, input int bad);
		logic [7:0] f[$], e[$];
		logic [15:0] cw, rw;
		int kind;
		kind = (bad != 0) ? 2 : kind_of(nd, adr);
		cw = 16'($urandom);
		rw = 16'($urandom);
		node_addr = nd;
		status_word = 16'($urandom);
		out_freq = 16'($urandom);
		frame(adr, {cw, rw}, 4, f);
		if (bad == 1)
			f[7] = f[7] ^ 8'h01;
		run(f, (bad == 2) ? 3 : -1, kind);
		if (kind != 2)
		begin
			last_cw = cw;
			last_rw = rw;
		end
		check(ctrl_word, last_cw);
		check(ref_word, last_rw);
		frame(adr, {status_word, out_freq}, 4, e);
		if (kind == 0)
			cmp(e, 0);
	endtask : proc
	// parameter telegram with rtx text bytes in the reply, wtx in the request
	task automatic param(input logic [3:0] c, input logic [7:0] ih, input logic flt,
		input logic [15:0] fc, input int rtx, input int wtx);
		logic [7:0] f[$], e[$];
		logic [95:0] x;
		logic [15:0] param_subindex_field, p1, p2;
		logic [11:0] pn;
		logic [31:0] v, pw;
		int r0, t0;
		pn = 12'($urandom);
		v = $urandom;
		param_subindex_field = {ih, 8'($urandom)};
		p1 = 16'($urandom);
		p2 = 16'($urandom);
		node_addr = 7'h05;
		rsp = '{flt, 1'($urandom), fc, $urandom, 8'(rtx)};
		x = {c, pn, param_subindex_field, v, p1, p2};
		frame(8'h05, (wtx != 0) ? {x, 16'h3031} : {16'h0, x}, 12 + wtx, f);
		r0 = rq_cnt;
		t0 = txt_cnt;
		run(f, -1, 0);
		last_cw = p1;
		last_rw = p2;
		pw = flt ? {16'h0000, fc} : rsp.value;
		x = {exp_nib(c, flt, rsp.dword), pn, param_subindex_field, pw, status_word, out_freq};
		frame(8'h05, (rtx != 0) ? {x, 16'ha0a1} : {16'h0, x}, 12 + rtx, e);
		check(rq_cnt - r0, 1);
		check(req_q.cmd, c);
		check(req_q.param_number_field, pn);
		check(req_q.subidx, param_subindex_field[7:0]);
		check(req_q.idx_hi, ih);
		check(req_q.value, v);
		check({req_q.bcast, req_q.txt_len}, wtx);
		check(txt_cnt - t0, wtx);
		if (wtx != 0)
			check(txt_q, 8'h31);
		check(ctrl_word, p1);
		check(ref_word, p2);
		cmp(e, 1);
	endtask : param
	// main sequence
	initial
	begin
		void'($urandom(10841));
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		check({tx_en, tx_valid, req_valid, frame_err, rsp_ready}, 0);
		foreach (adrs[i])
			proc(7'h05, adrs[i], 0);
		proc(7'h05, 8'h05, 1);
		proc(7'h05, 8'h05, 2);
		for (int i = 0; i < 12; i++)
			proc(7'(1 + $urandom % 126), 8'($urandom), 0);
		proc(7'h64, 8'he4, 0);
		for (int k = 0; k < 17; k++)
			param(cmds[k % 8], (cmds[k % 8] == 4'hf) ? dstf_pkg::TXT_RD : 8'($urandom),
				k >= 8, (k >= 8) ? flts[k - 8] : 16'h0, (k == 6) ? 2 : 0, 0);
		param(dstf_pkg::CMD_TEXT, dstf_pkg::TXT_WR, 1'b0, 16'h0, 0, 2);
		summarize();
	end
	// watchdog: 30000 cycles, about fifteen times the expected run of roughly two thousand cycles
	initial
	begin
		#300000;
		mismatches++;
		summarize();
	end
endmodule : tb
`default_nettype wire
